// ===== hdl/cpu_interrupt_sequencer.sv
// interrupt arbitration, entry and return sequencing with apb registers
// Overview of operation
// - reset and every source own a distinct vector, lowest addresses by default.
// - a source is enabled only with its own enable and global enable set.
// - lowest vector address wins; reset always has top priority.
// - vector-select bit moves the table to the boot section start.
// - boot-reset fuse moves the reset vector to the boot section start.
// - boot lock bits suppress interrupts depending on program counter region.
// - accepting an interrupt clears the global enable.
// - software may set global enable in a handler, allowing nesting.
// - return from handler sets the global enable.
// - flag sources have their flag cleared by hardware on vectoring.
// - writing one clears a flag; writing zero leaves it.
// - flags stay latched while disabled, then are served by priority.
// - level sources request only while their condition is present.
// - one main instruction runs after return before the next interrupt.
// - global disable acts at once, even against a same-cycle request.
// - the instruction after global enable runs before any interrupt.
// - entry takes at least four cycles while the pc is pushed.
// - a multi-cycle instruction completes before entry starts.
// - waking from sleep adds four cycles to entry.
// - return takes four cycles, pops pc, adds two to stack pointer.
// - saved and restored program counter is twelve bits wide.
// - global enable is status bit seven and masks all sources.
// - pushing the return address lowers the stack pointer by two.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_sequencer
  import cpu_interrupt_sequencer_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // peripheral requests
  input  wire logic [NUM_SOURCES-1:0] eventPulse,
  input  wire logic [NUM_SOURCES-1:0] levelCond,
  // fuses and lock bits
  input  wire logic                   boot_reset_fuse,
  input  wire logic                   boot_lock_app_bit,
  input  wire logic                   boot_lock_boot_bit,
  input  wire logic [PC_W-1:0]        bootSectionStart,
  // cpu pipeline side
  input  wire logic [PC_W-1:0]        currentPc,
  input  wire logic                   instrBoundary,
  input  wire logic                   sleeping,
  input  wire logic                   execSetGlobal,
  input  wire logic                   execClearGlobal,
  input  wire logic                   execReturn,
  input  wire logic [PC_W-1:0]        poppedPc,
  output logic                        cpuStall,
  output logic                        pushPc,
  output logic      [PC_W-1:0]        pushedPc,
  output logic                        popPc,
  output logic                        loadPc,
  output logic      [PC_W-1:0]        nextPc,
  output logic      [SP_W-1:0]        stackPointer,
  output logic      [SRC_IDX_W-1:0]   servedSource
);

  seq_state_t                   state;
  seq_state_t                   next_state;
  logic [7:0]                   statusFlags;
  logic [NUM_SOURCES-1:0]       enableMask;
  logic [NUM_SOURCES-1:0]       flags;
  logic [NUM_SOURCES-1:0]       levelType;
  logic [7:0]                   coreCtrl;
  logic [2:0]                   cycleCount;
  logic                         graceInstr;
  logic [SRC_IDX_W-1:0]         winner;
  logic [PC_W-1:0]              savedPc;
  logic                         started;

  // apb decode
  wire                          apbWrite     = psel & penable & pwrite;
  wire                          selStatus    = (paddr == ADDR_STATUS);
  wire                          selEnable    = (paddr == ADDR_FLAG_ENABLE);
  wire                          selFlags     = (paddr == ADDR_FLAGS);
  wire                          selLevel     = (paddr == ADDR_LEVEL_TYPE);
  wire                          selCtrl      = (paddr == ADDR_CORE_CTRL);
  wire                          selSp        = (paddr == ADDR_STACK_PTR);
  wire                          selPc        = (paddr == ADDR_SAVED_PC);
  wire                          selState     = (paddr == ADDR_STATE);
  wire                          mapped       = selStatus | selEnable | selFlags | selLevel |
                                               selCtrl | selSp | selPc | selState;
  wire                          wrStatus     = apbWrite & selStatus;
  wire                          wrFlags      = apbWrite & selFlags;
  wire                          wrEnable     = apbWrite & selEnable;
  wire                          wrLevel      = apbWrite & selLevel;
  wire                          wrCtrl       = apbWrite & selCtrl;
  wire                          wrSp         = apbWrite & selSp;
  wire                          apbAccess    = psel & penable;
  // read data is captured in the setup cycle
  wire                          readSetup    = psel & ~penable & ~pwrite;

  // no wait states; unmapped accesses are refused
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~mapped;

  // request formation
  wire                          globalEn     = statusFlags[GIE_BIT];
  wire [NUM_SOURCES-1:0]        rawReq       = (levelType & levelCond) |
                                               (~levelType & flags);
  wire [NUM_SOURCES-1:0]        enabledReq   = rawReq & enableMask;
  wire                          inBoot       = (currentPc >= bootSectionStart);
  wire                          lockSuppress = (boot_lock_app_bit & ~inBoot) |
                                               (boot_lock_boot_bit & inBoot);
  wire                          takeOk       = globalEn & ~execClearGlobal &
                                               ~execSetGlobal & ~graceInstr &
                                               ~lockSuppress & (|enabledReq);
  // state decode
  wire                          inRun        = (state == ST_RUN);
  wire                          inWake       = (state == ST_WAKE);
  wire                          inEntry      = (state == ST_ENTRY);
  wire                          inReturn     = (state == ST_RETURN);
  wire                          inHold       = (state == ST_HOLD);
  wire                          wakeLast     = inWake & (cycleCount == WAKE_EXTRA - 3'h1);
  wire                          entryLast    = inEntry & (cycleCount == ENTRY_CYCLES - 3'h1);
  wire                          returnLast   = inReturn & (cycleCount == RETURN_CYCLES - 3'h1);
  // needing a boundary lets multi-cycle instructions finish
  wire                          takeNow      = inRun & instrBoundary & takeOk;

  // lowest index is lowest vector address
  always_comb begin
    winner = '0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (enabledReq[i]) begin
        winner = SRC_IDX_W'(i);
      end
    end
  end

  wire [PC_W-1:0]               tableBase    = coreCtrl[VEC_SEL_BIT] ? BOOT_TABLE_BASE
                                                                     : APP_TABLE_BASE;
  // slot zero is reset, sources follow
  wire [PC_W-1:0]               vectorAddr   = tableBase + VECTOR_SPACING *
                                               (PC_W'(winner) + 12'h001);
  wire [PC_W-1:0]               resetVector  = boot_reset_fuse ? BOOT_TABLE_BASE
                                                               : APP_TABLE_BASE;

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (takeNow) begin
          next_state = sleeping ? ST_WAKE : ST_ENTRY;
        end else if (execReturn && instrBoundary) begin
          next_state = ST_RETURN;
        end
      end
      ST_WAKE: begin
        if (wakeLast) begin
          next_state = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (entryLast) begin
          next_state = ST_VECTOR;
        end
      end
      ST_VECTOR: next_state = ST_RUN;
      ST_RETURN: begin
        if (returnLast) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycleCount <= 3'h0;
    end else if (next_state != state) begin
      cycleCount <= 3'h0;
    end else begin
      cycleCount <= cycleCount + 3'h1;
    end
  end

  // latch winner and return address at acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      servedSource <= '0;
      savedPc      <= '0;
    end else if (takeNow) begin
      servedSource <= winner;
      savedPc      <= currentPc;
    end
  end

  // one main instruction after return or global enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      graceInstr <= 1'b0;
    end else if (inHold || execSetGlobal) begin
      graceInstr <= 1'b1;
    end else if (instrBoundary && inRun) begin
      graceInstr <= 1'b0;
    end
  end

  // status register: global enable
  // hardware updates outrank a same-cycle software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusFlags <= STATUS_RESET;
    end else if (takeNow) begin
      statusFlags[GIE_BIT] <= 1'b0;
    end else if (returnLast) begin
      statusFlags[GIE_BIT] <= 1'b1;
    end else if (execClearGlobal) begin
      statusFlags[GIE_BIT] <= 1'b0;
    end else if (execSetGlobal) begin
      statusFlags[GIE_BIT] <= 1'b1;
    end else if (wrStatus) begin
      statusFlags <= pwdata[7:0];
    end
  end

  // event flags, one per source
  wire                          vectoring    = (state == ST_VECTOR);
  generate
    for (genvar g = 0; g < NUM_SOURCES; g++) begin : gFlag
      wire hwClear = vectoring & (servedSource == SRC_IDX_W'(g)) & ~levelType[g];
      wire swClear = wrFlags & pwdata[g];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flags[g] <= 1'b0;
        // a new event wins over a same-cycle clear
        end else if (eventPulse[g]) begin
          flags[g] <= 1'b1;
        end else if (hwClear || swClear) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enableMask <= '0;
    end else if (wrEnable) begin
      enableMask <= pwdata[NUM_SOURCES-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levelType <= '0;
    end else if (wrLevel) begin
      levelType <= pwdata[NUM_SOURCES-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coreCtrl <= 8'h00;
    end else if (wrCtrl) begin
      coreCtrl <= pwdata[7:0];
    end
  end

  // stack pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stackPointer <= SP_RESET;
    end else if (takeNow) begin
      stackPointer <= stackPointer - PC_PUSH_BYTES;
    end else if (returnLast) begin
      stackPointer <= stackPointer + PC_PUSH_BYTES;
    end else if (wrSp) begin
      stackPointer <= pwdata[SP_W-1:0];
    end
  end

  // reset vector load after reset release
  // first edge after release loads the reset vector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  // pipeline outputs
  wire                          next_popPc   = inRun & execReturn & instrBoundary & ~takeNow;
  wire                          next_loadPc  = ~started | vectoring | inHold;
  // nextPc holds between loads
  wire [PC_W-1:0]               next_nextPc  = ~started  ? resetVector :
                                               vectoring ? vectorAddr  :
                                               inHold    ? poppedPc    :
                                                           nextPc;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pushPc <= 1'b0;
    end else begin
      pushPc <= takeNow;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      popPc <= 1'b0;
    end else begin
      popPc <= next_popPc;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loadPc <= 1'b0;
    end else begin
      loadPc <= next_loadPc;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pushedPc <= '0;
    end else if (takeNow) begin
      pushedPc <= currentPc;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nextPc <= '0;
    end else begin
      nextPc <= next_nextPc;
    end
  end

  assign cpuStall = (state != ST_RUN);

  // apb read mux
  wire [31:0]                   readMux      = selStatus ? {24'h000000, statusFlags}  :
                                               selEnable ? {24'h000000, enableMask}   :
                                               selFlags  ? {24'h000000, flags}        :
                                               selLevel  ? {24'h000000, levelType}    :
                                               selCtrl   ? {24'h000000, coreCtrl}     :
                                               selSp     ? {16'h0000, stackPointer}   :
                                               selPc     ? {20'h00000, savedPc}       :
                                               selState  ? {21'h0, enabledReq, state} :
                                                           32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (readSetup) begin
      prdata <= readMux;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/cpu_interrupt_sequencer_pkg.sv
// constants and types for the interrupt and reset sequencer
package cpu_interrupt_sequencer_pkg;

  localparam int          NUM_SOURCES      = 8;
  localparam int          SRC_IDX_W        = 3;
  localparam int          PC_W             = 12;
  localparam int          SP_W             = 16;
  localparam int          GIE_BIT          = 7;

  // register offsets (byte addresses)
  localparam logic [11:0] ADDR_STATUS      = 12'h000;
  localparam logic [11:0] ADDR_FLAG_ENABLE = 12'h004;
  localparam logic [11:0] ADDR_FLAGS       = 12'h008;
  localparam logic [11:0] ADDR_LEVEL_TYPE  = 12'h00c;
  localparam logic [11:0] ADDR_CORE_CTRL   = 12'h010;
  localparam logic [11:0] ADDR_STACK_PTR   = 12'h014;
  localparam logic [11:0] ADDR_SAVED_PC    = 12'h018;
  localparam logic [11:0] ADDR_STATE       = 12'h01c;

  // core control register fields
  localparam int          VEC_SEL_BIT      = 1;

  // reset values
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [15:0] SP_RESET         = 16'h0000;

  // vector placement
  localparam logic [11:0] APP_TABLE_BASE   = 12'h000;
  localparam logic [11:0] BOOT_TABLE_BASE  = 12'hc00;
  localparam logic [11:0] VECTOR_SPACING   = 12'h001;

  // timing, in cpu clock cycles; stack push size in bytes
  localparam logic [2:0]  ENTRY_CYCLES     = 3'h4;
  localparam logic [2:0]  WAKE_EXTRA       = 3'h4;
  localparam logic [2:0]  RETURN_CYCLES    = 3'h4;
  localparam logic [15:0] PC_PUSH_BYTES    = 16'h0002;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_WAKE   = 3'b001,
    ST_ENTRY  = 3'b011,
    ST_VECTOR = 3'b010,
    ST_RETURN = 3'b110,
    ST_HOLD   = 3'b111
  } seq_state_t;

endpackage

// ===== verification/cpu_core_model.sv
// cpu pipeline model: instruction boundaries, pc and a one-deep return stack
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model
  import cpu_interrupt_sequencer_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            cpuStall,
  input  wire logic            pushPc,
  input  wire logic [PC_W-1:0] pushedPc,
  input  wire logic            loadPc,
  input  wire logic [PC_W-1:0] nextPc,
  input  wire logic            doSet,
  input  wire logic            doClr,
  input  wire logic            doRet,
  output logic      [PC_W-1:0] currentPc,
  output logic                 instrBoundary,
  output logic                 execSetGlobal,
  output logic                 execClearGlobal,
  output logic                 execReturn,
  output var logic  [PC_W-1:0] poppedPc
);
  logic [1:0] phase;
  // every third instruction takes two cycles
  assign instrBoundary   = !cpuStall && phase != 2'h3;
  assign execSetGlobal   = instrBoundary && doSet;
  assign execClearGlobal = instrBoundary && doClr;
  assign execReturn      = instrBoundary && doRet;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase     <= 2'h0;
      currentPc <= '0;
      poppedPc  <= '0;
    end else begin
      if (!cpuStall) phase <= phase + 2'h1;
      if (loadPc) currentPc <= nextPc;
      else if (instrBoundary) currentPc <= currentPc + 12'h001;
      if (pushPc) poppedPc <= pushedPc;
    end
  end
endmodule
`default_nettype wire

// ===== verification/cpu_interrupt_sequencer_bench.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_sequencer_bench;
  import cpu_interrupt_sequencer_pkg::*;
  logic            clk, rst, psel, penable, pwrite, pready, pslverr, sleeping;
  logic            boot_lock_app_bit, instrBoundary, execSetGlobal, execClearGlobal;
  logic            execReturn, cpuStall, pushPc, popPc, loadPc, doSet, doClr, doRet, err, ok;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, q;
  logic [7:0]      eventPulse, levelCond, r;
  logic [PC_W-1:0] currentPc, poppedPc, pushedPc, nextPc;
  logic [SP_W-1:0] stackPointer;
  logic [2:0]      servedSource;
  int              fail_count = 0;
  int              n_tests = 0;

  cpu_interrupt_sequencer dut (.boot_reset_fuse(1'b0), .boot_lock_boot_bit(1'b0),
    .bootSectionStart(BOOT_TABLE_BASE), .*);
  cpu_core_model core (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // k: 0 set enable, 1 clear enable, 2 return, 3 plain instruction
  task automatic exec(input int k, input logic [7:0] ev);
    @(posedge clk);
    doSet <= k == 0;
    doClr <= k == 1;
    doRet <= k == 2;
    eventPulse <= ev;
    do begin
      @(posedge clk);
      eventPulse <= 8'h00;
    end while (instrBoundary !== 1'b1);
    {doSet, doClr, doRet} <= 3'h0;
  endtask

  task automatic waitload();
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk);
      ok = loadPc;
    end
  endtask

  function automatic logic [2:0] lowest(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) if (v[i]) lowest = 3'(i);
  endfunction

  task automatic serve(input logic [2:0] idx, input logic [11:0] base, input logic last);
    logic [31:0] st;
    logic [31:0] sv;
    waitload();
    levelCond <= 8'h00;
    sleeping <= 1'b0;
    check(ok, 1'b1);
    check(nextPc, base + (12'(idx) + 12'h001) * VECTOR_SPACING);
    check(servedSource, idx);
    apb(1'b0, ADDR_STATUS, 32'h0);
    st = q;
    check(q[GIE_BIT], 1'b0);
    apb(1'b0, ADDR_STACK_PTR, 32'h0);
    check(q, 32'h04fe - PC_PUSH_BYTES);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q[idx], 1'b0);
    apb(1'b0, ADDR_SAVED_PC, 32'h0);
    sv = q;
    apb(1'b1, ADDR_STATUS, st);
    exec(2, 8'h00);
    waitload();
    check(ok, 1'b1);
    check(nextPc, sv[11:0]);
    if (last) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(q[GIE_BIT], 1'b1);
      apb(1'b0, ADDR_STACK_PTR, 32'h0);
      check(q, 32'h04fe);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    {psel, penable, pwrite, sleeping, boot_lock_app_bit, doSet, doClr, doRet} = 8'h00;
    {paddr, pwdata, eventPulse, levelCond} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'h10d6446c));
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q, {24'h0, STATUS_RESET});
    apb(1'b0, ADDR_STACK_PTR, 32'h0);
    check(q, {16'h0, SP_RESET});
    apb(1'b0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    check(q, 32'h0);
    $display("test reset done");
    apb(1'b1, ADDR_STACK_PTR, 32'h04fe);
    apb(1'b1, ADDR_FLAG_ENABLE, 32'hff);
    r = 8'($urandom) | 8'h10;
    exec(3, r);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, {24'h0, r});
    exec(0, 8'h00);
    while (r != 8'h00) begin
      serve(lowest(r), APP_TABLE_BASE, r == (8'h01 << lowest(r)));
      r[lowest(r)] = 1'b0;
    end
    $display("test priority done");
    exec(1, 8'h0f);
    waitload();
    check(ok, 1'b0);
    apb(1'b1, ADDR_FLAGS, 32'h05);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, 32'h0a);
    apb(1'b1, ADDR_FLAG_ENABLE, 32'h00);
    exec(0, 8'h00);
    waitload();
    check(ok, 1'b0);
    apb(1'b1, ADDR_FLAGS, 32'h0a);
    apb(1'b1, ADDR_FLAG_ENABLE, 32'hff);
    $display("test masking done");
    apb(1'b1, ADDR_CORE_CTRL, 32'h1 << VEC_SEL_BIT);
    sleeping <= 1'b1;
    exec(3, 8'h20);
    serve(3'h5, BOOT_TABLE_BASE, 1'b1);
    apb(1'b1, ADDR_CORE_CTRL, 32'h0);
    $display("test boot table done");
    exec(1, 8'h00);
    apb(1'b1, ADDR_LEVEL_TYPE, 32'h40);
    levelCond <= 8'h40;
    repeat (2) @(posedge clk);
    levelCond <= 8'h00;
    exec(0, 8'h00);
    waitload();
    check(ok, 1'b0);
    boot_lock_app_bit <= 1'b1;
    levelCond <= 8'h40;
    waitload();
    check(ok, 1'b0);
    boot_lock_app_bit <= 1'b0;
    serve(3'h6, APP_TABLE_BASE, 1'b1);
    $display("test level and lock done");
    results();
  end
endmodule
`default_nettype wire

// ===== verification/cpu_interrupt_sequencer_chk.sv
// port-level assertions for the interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_sequencer_chk
  import cpu_interrupt_sequencer_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 boot_reset_fuse,
  input wire logic                 sleeping,
  input wire logic                 execSetGlobal,
  input wire logic                 execClearGlobal,
  input wire logic [PC_W-1:0]      poppedPc,
  input wire logic                 cpuStall,
  input wire logic                 pushPc,
  input wire logic                 popPc,
  input wire logic                 loadPc,
  input wire logic [PC_W-1:0]      nextPc,
  input wire logic [SP_W-1:0]      stackPointer,
  input wire logic [SRC_IDX_W-1:0] servedSource
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  entry_time_a: assert property (pushPc && !$past(sleeping) |->
    cpuStall [*4] ##1 !loadPc ##1 loadPc) else $error("entry length wrong");
  wake_time_a: assert property (pushPc && $past(sleeping) |-> ##9 loadPc)
    else $error("wake entry length wrong");
  vector_addr_a: assert property (pushPc && !$past(sleeping) |->
    ##5 nextPc[9:0] == 10'(servedSource) + 10'h001) else $error("vector address wrong");
  push_sp_a: assert property (pushPc |->
    stackPointer == $past(stackPointer) - PC_PUSH_BYTES) else $error("push stack wrong");
  return_pc_a: assert property (popPc |-> ##5 loadPc && nextPc == $past(poppedPc))
    else $error("return sequence wrong");
  clear_block_a: assert property (execClearGlobal |=> !pushPc)
    else $error("entry after global disable");
  set_grace_a: assert property (execSetGlobal |=> !pushPc)
    else $error("entry right after global enable");
  return_gap_a: assert property (popPc |-> ##6 !pushPc)
    else $error("entry before one instruction");
  reset_vec_a: assert property ($fell(rst) |=> loadPc &&
    nextPc == (boot_reset_fuse ? BOOT_TABLE_BASE : APP_TABLE_BASE)) else $error("reset vector");
endmodule
bind cpu_interrupt_sequencer cpu_interrupt_sequencer_chk chk (.*);
`default_nettype wire
